// File: common/pxr_regs.vh
// Constants shared by the management register bank: offsets, fields, resets and timing counts.
// How it works
// - Function 00: window reads and writes go to the extended register pointer.
// - Function 01: window reaches pointed extended register, pointer unchanged.
// - Function 10: window reaches pointed register, pointer increments after reads and writes.
// - Function 11: window reaches pointed register, pointer increments after writes only.
// - Control bits 4:0 hold the device address; only all ones opens the window.
// - Window accesses with any other device address are acknowledged, change nothing and read zero.
// - Control bits 13:5 read zero; function and address fields reset zero, read-write.
// - Window is 16 bits: pointer in address function, else pointed data.
// - Gigabit ability status reads bits 15:14 zero and bits 13:12 one.
// - Gigabit ability status bits 11:0 ignore writes and read zero.
// - Transmit FIFO depth in bits 15:14 selects 8, 6, 4, 3 entries.
// - Transmit FIFO active at gigabit parallel, or any speed but the reserved code with serial interface.
// - Receive FIFO depth in bits 13:12 uses the same encoding.
// - Receive FIFO active only with the serial interface selected.
// - Control bit 11 enables serial interface; reset value from strap, read-write.
// - Control bit 10 forces link good; clear at reset restores normal qualification.
// - Extended registers sit above 0x001F and are reached only through the window.
`ifndef PXR_REGS_VH
`define PXR_REGS_VH

// Register offsets in the management space.
`define PXR_ADDR_CTRL        5'h0D
`define PXR_ADDR_WINDOW      5'h0E
`define PXR_ADDR_GIG_STATUS  5'h0F
`define PXR_ADDR_PHY_CTRL    5'h10

// Access control fields.
`define PXR_FUNC_HI          15
`define PXR_FUNC_LO          14
`define PXR_TGT_DEV_HI       4
`define PXR_TGT_DEV_LO       0
`define PXR_TGT_DEV_VENDOR   5'h1F
`define PXR_FUNC_ADDRESS     2'h0
`define PXR_FUNC_DATA        2'h1
`define PXR_FUNC_DATA_INC_RW 2'h2
`define PXR_FUNC_DATA_INC_W  2'h3
`define PXR_FUNC_RESET       2'h0
`define PXR_TGT_DEV_RESET    5'h00
`define PXR_PTR_RESET        16'h0000
`define PXR_PTR_STEP         16'h0001

// Extended register space starts just above the direct registers.
`define PXR_EXT_BASE         16'h0020

// Gigabit ability status, constant.
`define PXR_GIG_STATUS_VALUE 16'h3000

// General control fields.
`define PXR_TXD_HI           15
`define PXR_TXD_LO           14
`define PXR_RXD_HI           13
`define PXR_RXD_LO           12
`define PXR_SERIAL_EN_BIT    11
`define PXR_FORCE_LINK_BIT   10
`define PXR_TXD_RESET        2'h1
`define PXR_RXD_RESET        2'h1
`define PXR_FORCE_LINK_RESET 1'b0

// FIFO depth codes and entry counts.
`define PXR_DEPTH_CODE_8     2'h3
`define PXR_DEPTH_CODE_6     2'h2
`define PXR_DEPTH_CODE_4     2'h1
`define PXR_DEPTH_COUNT_8    4'h8
`define PXR_DEPTH_COUNT_6    4'h6
`define PXR_DEPTH_COUNT_4    4'h4
`define PXR_DEPTH_COUNT_3    4'h3
`define PXR_DEPTH_NONE       4'h0

// Line speed codes.
`define PXR_SPEED_10         2'h0
`define PXR_SPEED_100        2'h1
`define PXR_SPEED_1000       2'h2
`define PXR_SPEED_RESERVED   2'h3

// Cycles after reset release before the strap is taken and requests are served.
`define PXR_STRAP_SETTLE     2'h2

`endif

// File: hdl/pxr_ext_bank.v
// Extended register storage reached only through the indirect window.
`timescale 1ns/100ps
`include "pxr_regs.vh"

module pxr_ext_bank #(
  parameter IDX_W = 5
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Access from the window logic.
  input  wire        wr_en,
  input  wire [15:0] addr,
  input  wire [15:0] wdata,
  output wire        hit,
  output wire [15:0] rdata
);

  localparam DEPTH = 1 << IDX_W;

  reg  [15:0]      mem [0:DEPTH-1];
  wire [15:0]      offset;
  wire [IDX_W-1:0] idx;

  // Pointers below the base address the direct registers, which the window never reaches.
  assign offset = addr - `PXR_EXT_BASE;
  assign idx    = offset[IDX_W-1:0];
  assign hit    = (addr >= `PXR_EXT_BASE) && (offset[15:IDX_W] == {(16-IDX_W){1'b0}});
  assign rdata  = hit ? mem[idx] : 16'h0000;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      localparam [IDX_W-1:0] ENTRY = i;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem[i] <= 16'h0000;
        end else if (wr_en && hit && (idx == ENTRY)) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

endmodule // pxr_ext_bank

// File: hdl/pxr_mgmt_regs.v
// Management register bank: indirect extended access, gigabit ability status and general control.
`timescale 1ns/100ps
`include "pxr_regs.vh"

module pxr_mgmt_regs #(
  parameter EXT_IDX_W = 5
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Strap pin, asynchronous to clk.
  input  wire        serial_en_strap,
  // Register transaction port from the management frame decoder.
  input  wire        mgmt_req,
  input  wire        mgmt_write,
  input  wire [4:0]  mgmt_addr,
  input  wire [15:0] mgmt_wdata,
  output reg         mgmt_ack,
  output reg  [15:0] mgmt_rdata,
  output reg         mgmt_ready,
  // Line state from the physical layer logic.
  input  wire [1:0]  line_speed,
  input  wire        link_qualified,
  // Settings to the data path.
  output reg         serial_mac_en,
  output reg         force_link_good,
  output reg         link_good,
  output reg         tx_fifo_active,
  output reg  [3:0]  tx_fifo_depth,
  output reg         rx_fifo_active,
  output reg  [3:0]  rx_fifo_depth,
  // Window pointer, for observation.
  output reg  [15:0] ext_pointer
);

  // Maps a depth code to an entry count.
  function [3:0] depth_count;
    input [1:0] code;
    begin
      case (code)
        `PXR_DEPTH_CODE_8: depth_count = `PXR_DEPTH_COUNT_8;
        `PXR_DEPTH_CODE_6: depth_count = `PXR_DEPTH_COUNT_6;
        `PXR_DEPTH_CODE_4: depth_count = `PXR_DEPTH_COUNT_4;
        default:           depth_count = `PXR_DEPTH_COUNT_3;
      endcase
    end
  endfunction

  // Strap capture state.
  reg        strap_sync1;
  reg        strap_sync2;
  reg [1:0]  settle_cnt;

  // Access control fields.
  reg [1:0]  func;
  reg [4:0]  target_device_address_field;

  // General control fields.
  reg [1:0]  tx_depth_code;
  reg [1:0]  rx_depth_code;

  // Decoded transaction.
  wire       take;
  wire       wr;
  wire       rd;
  wire       sel_ctrl;
  wire       sel_window;
  wire       sel_gig;
  wire       sel_phy;
  wire       tgt_dev_ok;
  wire       win_addr_fn;
  wire       win_data_fn;
  wire       win_active;
  wire       ext_wr;
  wire       ptr_inc;
  wire       ext_hit;
  wire [15:0] ext_rdata;

  // Combinational next values.
  reg [15:0] next_rdata;
  reg [15:0] next_pointer;
  reg        next_tx_active;
  reg        next_rx_active;

  // The first flop of the strap synchroniser feeds only the second one.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync1 <= 1'b0;
      strap_sync2 <= 1'b0;
    end else begin
      strap_sync1 <= serial_en_strap;
      strap_sync2 <= strap_sync1;
    end
  end

  // Requests are held off until the strap has passed the synchroniser and been taken.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
      mgmt_ready <= 1'b0;
    end else if (!mgmt_ready) begin
      if (settle_cnt == `PXR_STRAP_SETTLE) begin
        mgmt_ready <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  assign take        = mgmt_req && mgmt_ready;
  assign wr          = take && mgmt_write;
  assign rd          = take && !mgmt_write;
  assign sel_ctrl    = (mgmt_addr == `PXR_ADDR_CTRL);
  assign sel_window  = (mgmt_addr == `PXR_ADDR_WINDOW);
  assign sel_gig     = (mgmt_addr == `PXR_ADDR_GIG_STATUS);
  assign sel_phy     = (mgmt_addr == `PXR_ADDR_PHY_CTRL);
  assign tgt_dev_ok  = (target_device_address_field == `PXR_TGT_DEV_VENDOR);
  assign win_active  = take && sel_window && tgt_dev_ok;
  assign win_addr_fn = (func == `PXR_FUNC_ADDRESS);
  assign win_data_fn = !win_addr_fn;
  assign ext_wr      = win_active && win_data_fn && mgmt_write;

  // Post increment: both directions in one mode, writes only in the other.
  assign ptr_inc = win_active &&
                   ((func == `PXR_FUNC_DATA_INC_RW) ||
                    ((func == `PXR_FUNC_DATA_INC_W) && mgmt_write));

  pxr_ext_bank #(
    .IDX_W (EXT_IDX_W)
  ) u_ext_bank (
    .clk   (clk),
    .rst_n (rst_n),
    .wr_en (ext_wr),
    .addr  (ext_pointer),
    .wdata (mgmt_wdata),
    .hit   (ext_hit),
    .rdata (ext_rdata)
  );

  // Access control register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func  <= `PXR_FUNC_RESET;
      target_device_address_field <= `PXR_TGT_DEV_RESET;
    end else if (wr && sel_ctrl) begin
      func  <= mgmt_wdata[`PXR_FUNC_HI:`PXR_FUNC_LO];
      target_device_address_field <= mgmt_wdata[`PXR_TGT_DEV_HI:`PXR_TGT_DEV_LO];
    end
  end

  // Pointer load and post increment; the 16-bit add wraps on its own.
  always @* begin
    next_pointer = ext_pointer;
    if (win_active && win_addr_fn && mgmt_write) begin
      next_pointer = mgmt_wdata;
    end else if (ptr_inc) begin
      next_pointer = ext_pointer + `PXR_PTR_STEP;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pointer <= `PXR_PTR_RESET;
    end else begin
      ext_pointer <= next_pointer;
    end
  end

  // General control register; the serial enable takes the strap once at the end of settling.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_depth_code   <= `PXR_TXD_RESET;
      rx_depth_code   <= `PXR_RXD_RESET;
      serial_mac_en   <= 1'b0;
      force_link_good <= `PXR_FORCE_LINK_RESET;
    end else if (!mgmt_ready) begin
      if (settle_cnt == `PXR_STRAP_SETTLE) begin
        serial_mac_en <= strap_sync2;
      end
    end else if (wr && sel_phy) begin
      tx_depth_code   <= mgmt_wdata[`PXR_TXD_HI:`PXR_TXD_LO];
      rx_depth_code   <= mgmt_wdata[`PXR_RXD_HI:`PXR_RXD_LO];
      serial_mac_en   <= mgmt_wdata[`PXR_SERIAL_EN_BIT];
      force_link_good <= mgmt_wdata[`PXR_FORCE_LINK_BIT];
    end
  end

  // Read data selection.
  always @* begin
    next_rdata = 16'h0000;
    if (sel_ctrl) begin
      next_rdata[`PXR_FUNC_HI:`PXR_FUNC_LO]   = func;
      next_rdata[`PXR_TGT_DEV_HI:`PXR_TGT_DEV_LO] = target_device_address_field;
    end else if (sel_window) begin
      // A window read with the wrong device address returns zero and changes nothing.
      if (!tgt_dev_ok) begin
        next_rdata = 16'h0000;
      end else if (win_addr_fn) begin
        next_rdata = ext_pointer;
      end else begin
        next_rdata = ext_hit ? ext_rdata : 16'h0000;
      end
    end else if (sel_gig) begin
      next_rdata = `PXR_GIG_STATUS_VALUE;
    end else if (sel_phy) begin
      next_rdata[`PXR_TXD_HI:`PXR_TXD_LO]  = tx_depth_code;
      next_rdata[`PXR_RXD_HI:`PXR_RXD_LO]  = rx_depth_code;
      next_rdata[`PXR_SERIAL_EN_BIT]       = serial_mac_en;
      next_rdata[`PXR_FORCE_LINK_BIT]      = force_link_good;
    end
  end

  // One answer per taken request, one cycle later, for reads and writes alike.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_ack   <= 1'b0;
      mgmt_rdata <= 16'h0000;
    end else begin
      mgmt_ack <= take;
      if (rd) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end

  // FIFO enables depend on interface mode and line speed.
  always @* begin
    next_rx_active = serial_mac_en;
    if (serial_mac_en) begin
      next_tx_active = (line_speed != `PXR_SPEED_RESERVED);
    end else begin
      next_tx_active = (line_speed == `PXR_SPEED_1000);
    end
  end

  // Settings to the data path; an inactive FIFO reports no depth.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fifo_active <= 1'b0;
      tx_fifo_depth  <= `PXR_DEPTH_NONE;
      rx_fifo_active <= 1'b0;
      rx_fifo_depth  <= `PXR_DEPTH_NONE;
      link_good      <= 1'b0;
    end else begin
      tx_fifo_active <= next_tx_active;
      tx_fifo_depth  <= next_tx_active ? depth_count(tx_depth_code) : `PXR_DEPTH_NONE;
      rx_fifo_active <= next_rx_active;
      rx_fifo_depth  <= next_rx_active ? depth_count(rx_depth_code) : `PXR_DEPTH_NONE;
      link_good      <= force_link_good | link_qualified;
    end
  end

endmodule // pxr_mgmt_regs

// File: verif/pxr_mgmt_regs_chk.sv
// Port checker for the management register bank.
`timescale 1ns/100ps
`include "pxr_regs.vh"
module pxr_mgmt_regs_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port.
  input wire logic        mgmt_req,
  input wire logic        mgmt_write,
  input wire logic [4:0]  mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic        mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        mgmt_ready,
  // Data path side.
  input wire logic        link_qualified,
  input wire logic        force_link_good,
  input wire logic        link_good,
  input wire logic        serial_mac_en,
  input wire logic        rx_fifo_active,
  input wire logic [15:0] ext_pointer
);
  logic [1:0] fn;
  logic [4:0] dv;
  wire        tk = mgmt_req & mgmt_ready;
  wire        aw = tk & (mgmt_addr == `PXR_ADDR_WINDOW);
  wire        wa = aw & (dv == `PXR_TGT_DEV_VENDOR);
  // Shadow of the control fields, so window checks know the mode in force.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fn <= 2'h0;
      dv <= 5'h00;
    end else if (tk & mgmt_write & (mgmt_addr == `PXR_ADDR_CTRL)) begin
      fn <= mgmt_wdata[15:14];
      dv <= mgmt_wdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_after_take_a: assert property (tk |=> mgmt_ack)
    else $error("no ack after taken request");
  ack_no_req_a: assert property (!tk |=> !mgmt_ack)
    else $error("ack without request");
  gig_status_a: assert property (tk && !mgmt_write && mgmt_addr == `PXR_ADDR_GIG_STATUS |=> mgmt_rdata == 16'h3000)
    else $error("gigabit status read wrong");
  ctrl_read_a: assert property (tk && !mgmt_write && mgmt_addr == `PXR_ADDR_CTRL |=> mgmt_rdata == {fn, 9'h000, dv})
    else $error("control read wrong");
  ptr_load_a: assert property (wa && mgmt_write && fn == 2'h0 |=> ext_pointer == $past(mgmt_wdata))
    else $error("pointer not loaded");
  ptr_step_a: assert property (wa && fn == 2'h2 |=> ext_pointer == $past(ext_pointer) + 16'h0001)
    else $error("pointer not stepped");
  ptr_step_write_a: assert property (wa && fn == 2'h3 && mgmt_write |=> ext_pointer == $past(ext_pointer) + 16'h0001)
    else $error("pointer not stepped on write");
  ptr_hold_a: assert property (aw && (dv != 5'h1F || fn == 2'h1 || (fn == 2'h3 && !mgmt_write)) |=> $stable(ext_pointer))
    else $error("pointer moved");
  addr_read_a: assert property (wa && !mgmt_write && fn == 2'h0 |=> mgmt_rdata == $past(ext_pointer))
    else $error("pointer read wrong");
  link_good_a: assert property (1'b1 |=> link_good == $past(force_link_good | link_qualified))
    else $error("link good wrong");
  rx_follow_a: assert property (1'b1 |=> rx_fifo_active == $past(serial_mac_en))
    else $error("rx fifo activity wrong");
  c_step: cover property (wa && fn == 2'h2);
  c_gig: cover property (tk && mgmt_addr == `PXR_ADDR_GIG_STATUS);
  c_force: cover property (force_link_good && !link_qualified);
endmodule // pxr_mgmt_regs_chk

bind pxr_mgmt_regs pxr_mgmt_regs_chk chk (
  .clk(clk), .rst_n(rst_n), .mgmt_req(mgmt_req), .mgmt_write(mgmt_write),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_ack(mgmt_ack),
  .mgmt_rdata(mgmt_rdata), .mgmt_ready(mgmt_ready), .link_qualified(link_qualified),
  .force_link_good(force_link_good), .link_good(link_good),
  .serial_mac_en(serial_mac_en), .rx_fifo_active(rx_fifo_active), .ext_pointer(ext_pointer)
);

// File: verif/pxr_host_model.sv
// Management host model issuing single register transactions.
`timescale 1ns/100ps
module pxr_host_model (
  // Clock.
  input  wire logic        clk,
  // Register port toward the bank.
  input  wire logic        ready,
  input  wire logic        ack,
  input  wire logic [15:0] rdata,
  output logic             req,
  output logic             write,
  output logic [4:0]       addr,
  output logic [15:0]      wdata
);
  initial begin
    req = 1'b0;
    write = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
  end
  // Address and data lines are inverted once the strobe drops, so a late sample cannot match by luck.
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic ok, output logic [15:0] q);
    integer i;
    i = 0;
    while (ready !== 1'b1 && i < 64) begin
      @(posedge clk);
      #1;
      i = i + 1;
    end
    req = 1'b1;
    write = w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    req = 1'b0;
    addr = ~a;
    wdata = ~d;
    ok = ack;
    q = rdata;
    @(posedge clk);
    #1;
  endtask
endmodule // pxr_host_model

// File: verif/test_phy_extended_reg_indirect_access.sv
// Self-checking bench for the management register bank.
`timescale 1ns/100ps
`include "pxr_regs.vh"
module test_phy_extended_reg_indirect_access;
  logic        clk, rst_n, strap, lq, ok;
  logic [1:0]  speed;
  logic [15:0] q;
  wire         req, wr_n1, ack, rdy, ser, frc, lg, txa, rxa;
  wire  [4:0]  addr;
  wire  [15:0] wd, rd_d, ptr;
  wire  [3:0]  txd, rxd;
  integer      fails, n_checks;
  pxr_host_model host (.clk(clk), .ready(rdy), .ack(ack), .rdata(rd_d), .req(req),
    .write(wr_n1), .addr(addr), .wdata(wd));
  pxr_mgmt_regs dut (.clk(clk), .rst_n(rst_n), .serial_en_strap(strap), .mgmt_req(req),
    .mgmt_write(wr_n1), .mgmt_addr(addr), .mgmt_wdata(wd), .mgmt_ack(ack), .mgmt_rdata(rd_d),
    .mgmt_ready(rdy), .line_speed(speed), .link_qualified(lq), .serial_mac_en(ser),
    .force_link_good(frc), .link_good(lg), .tx_fifo_active(txa), .tx_fifo_depth(txd),
    .rx_fifo_active(rxa), .rx_fifo_depth(rxd), .ext_pointer(ptr));
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, ok, q);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000, ok, q);
    chk({15'h0000, ok}, 16'h0001);
    chk(q, e);
  endtask
  task setp(input logic [15:0] p, input logic [1:0] f);
    wr(`PXR_ADDR_CTRL, 16'h001F);
    wr(`PXR_ADDR_WINDOW, p);
    wr(`PXR_ADDR_CTRL, {f, 14'h001F});
  endtask
  task dpath(input logic [15:0] e);
    chk({4'h0, txa, txd, rxa, rxd, frc, lg}, e);
  endtask
  task t_reset;
    rd(`PXR_ADDR_CTRL, 16'h0000);
    rd(`PXR_ADDR_PHY_CTRL, 16'h5800);
    chk(ptr, 16'h0000);
    $display("reset test done");
  endtask
  task t_regs;
    wr(`PXR_ADDR_CTRL, 16'hFFFF);
    rd(`PXR_ADDR_CTRL, 16'hC01F);
    wr(`PXR_ADDR_GIG_STATUS, 16'h0FFF);
    rd(`PXR_ADDR_GIG_STATUS, 16'h3000);
    rd(5'h05, 16'h0000);
    $display("register test done");
  endtask
  task t_funcs;
    integer f;
    logic [15:0] p;
    for (f = 1; f < 4; f = f + 1) begin
      p = 16'h0020 + f[15:0];
      setp(p, 2'h0);
      rd(`PXR_ADDR_WINDOW, p);
      setp(p, f[1:0]);
      wr(`PXR_ADDR_WINDOW, 16'hA500 + f[15:0]);
      chk(ptr, p + ((f == 1) ? 16'h0000 : 16'h0001));
      setp(p, f[1:0]);
      rd(`PXR_ADDR_WINDOW, 16'hA500 + f[15:0]);
      chk(ptr, p + ((f == 2) ? 16'h0001 : 16'h0000));
    end
    $display("function test done");
  endtask
  task t_target_device_address_field;
    setp(16'h0021, `PXR_FUNC_DATA);
    wr(`PXR_ADDR_CTRL, 16'h0005);
    wr(`PXR_ADDR_WINDOW, 16'h0030);
    wr(`PXR_ADDR_CTRL, 16'h4005);
    wr(`PXR_ADDR_WINDOW, 16'h1234);
    rd(`PXR_ADDR_WINDOW, 16'h0000);
    chk(ptr, 16'h0021);
    wr(`PXR_ADDR_CTRL, 16'h401F);
    rd(`PXR_ADDR_WINDOW, 16'hA501);
    setp(16'hFFFF, `PXR_FUNC_DATA_INC_RW);
    rd(`PXR_ADDR_WINDOW, 16'h0000);
    chk(ptr, 16'h0000);
    $display("address and wrap test done");
  endtask
  task t_phy;
    integer c;
    logic [3:0] e;
    for (c = 0; c < 4; c = c + 1) begin
      e = (c == 3) ? 4'h8 : (c == 2) ? 4'h6 : (c == 1) ? 4'h4 : 4'h3;
      wr(`PXR_ADDR_PHY_CTRL, {c[1:0], c[1:0], 12'hFFF});
      dpath({4'h0, 1'b1, e, 1'b1, e, 2'b11});
      rd(`PXR_ADDR_PHY_CTRL, {c[1:0], c[1:0], 12'hC00});
    end
    speed = `PXR_SPEED_100;
    repeat (2) @(posedge clk);
    #1;
    dpath({4'h0, 1'b1, 4'h8, 1'b1, 4'h8, 2'b11});
    wr(`PXR_ADDR_PHY_CTRL, 16'h0000);
    dpath(16'h0000);
    speed = `PXR_SPEED_1000;
    repeat (2) @(posedge clk);
    #1;
    dpath({4'h0, 1'b1, 4'h3, 1'b0, 4'h0, 2'b00});
    $display("control test done");
  endtask
  // Mid-run reset with the strap low; also covers a qualified link, 10 Mb/s and the reserved speed code.
  task t_strap;
    rst_n = 1'b0;
    strap = 1'b0;
    lq = 1'b1;
    speed = `PXR_SPEED_10;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk({14'h0000, rdy, ack}, 16'h0000);
    rd(`PXR_ADDR_PHY_CTRL, 16'h5000);
    dpath({4'h0, 1'b0, 4'h0, 1'b0, 4'h0, 2'b01});
    wr(`PXR_ADDR_PHY_CTRL, 16'h0800);
    dpath({4'h0, 1'b1, 4'h3, 1'b1, 4'h3, 2'b01});
    speed = `PXR_SPEED_RESERVED;
    repeat (2) @(posedge clk);
    #1;
    dpath({4'h0, 1'b0, 4'h0, 1'b1, 4'h3, 2'b01});
    $display("strap and speed test done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    strap = 1'b1;
    lq = 1'b0;
    speed = `PXR_SPEED_1000;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_funcs;
    t_target_device_address_field;
    t_phy;
    t_strap;
    close_out;
  end
  initial begin
    #40000;
    fails = fails + 1;
    close_out;
  end
endmodule // test_phy_extended_reg_indirect_access
